// >>> rtl/dcm_match.sv
// Purpose: three address comparators, A also comparing data, with sticky match flags behind a banked window
// Assumes: core bus and execute inputs come from logic on core_clk
// Notes: sequencer tables and trace buffer live elsewhere; breakpoint and trace stop events are generated here
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - flag register shows at index 0x27 only when window select is 11; writes ignored
// - three sticky flags, one per channel, set on session match until next arm
// - software cannot clear flags; only arming clears them, so they survive the session
// - flags set independently; repeat matches leave a set flag unchanged
// - one shared eight-byte window; A has all bytes, B and C four
// - unimplemented window bytes read zero and drop writes
// - control at 0x28, address high 0x29, middle 0x2A, low 0x2B for each comparator
// - comparator A data compare at 0x2C/0x2D, data mask at 0x2E/0x2F
// - window select 00/01/10 picks A/B/C; writes only while not armed
// - bits 7 and 6 are size enable and size value for A and B only
// - size enable with tag clear: value 0 needs word, 1 needs byte access
// - tag clear matches immediately; tag set matches when opcode reaches execution
// - break bit match ends session: breakpoint, trace stop, disarm
// - immediate breakpoint only when module breakpoint enable is set
// - direction enable 0 ignores direction; 1 with value 0 writes, 1 reads
// - direction enabled and bus direction differs: no match
// - tag set ignores size, direction and data inversion settings
// - comparator A inversion bit: 0 match equality, 1 match difference
// - comparator with enable bit clear never matches
// - simultaneous matches: lowest-numbered channel reported first
// - data compare bit used only where mask bit is 1
// - every address bit compared; high byte holds address bits 17 and 16
module dcm_match
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // axi4-lite write address and data
   input wire logic [dcm_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [dcm_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // core side
   input wire dcm_pkg::dcm_core_bus_t coreBus,
   input wire dcm_pkg::dcm_exec_t coreExec,
   // events to sequencer
   output dcm_pkg::dcm_event_t debugEvent
);
   import dcm_pkg::*;

   logic awReadyReg;
   logic bValidReg;
   logic [1:0] bRespReg;
   logic arReadyReg;
   logic rValidReg;
   logic [1:0] rRespReg;
   logic [31:0] rDataReg;
   logic [7:0] ctrlReg [NUM_CHAN];
   logic [1:0] addrHiReg [NUM_CHAN];
   logic [7:0] addrMidReg [NUM_CHAN];
   logic [7:0] addrLoReg [NUM_CHAN];
   logic [15:0] dataCmpReg;
   logic [15:0] dataMaskReg;
   logic [1:0] winSelReg;
   logic brkEnReg;
   logic armedReg;
   logic [2:0] flagsReg;
   logic [2:0] flagsNext;
   dcm_event_t eventReg;
   logic [2:0] chanHit;
   logic [2:0] sessionHit;
   logic wrFire;
   logic rdFire;
   logic [5:0] wrIdx;
   logic [5:0] rdIdx;
   logic [7:0] wrByte;
   logic armWr;
   logic cmpWrOk;
   logic breakHit;
   logic [7:0] rdByte;
   logic rdMapped;

   // ***************************************
   // helpers
   // ***************************************
   function automatic logic [5:0] regIndex(input logic [AXI_ADDR_W-1:0] a);
      regIndex = a[7:2];
   endfunction

   function automatic logic isMapped(input logic [AXI_ADDR_W-1:0] a);
      logic [5:0] idx;
      idx = a[7:2];
      isMapped = (a[1:0] == 2'h0) && (idx == MAIN_CTRL_IDX || (idx >= MATCH_FLAGS_IDX && idx <= CMP_MASK_LO_IDX));
   endfunction

   function automatic logic [2:0] lowestOne(input logic [2:0] v);
      lowestOne = v & ~(v - 3'h1);
   endfunction

   // one comparator; hasSize and hasData say which optional parts this channel owns
   function automatic logic chanMatch(input logic [7:0] ctl, input logic [17:0] cmpAddr, input logic hasSize,
                                      input logic hasData, input logic [15:0] dCmp, input logic [15:0] dMask,
                                      input dcm_core_bus_t bus, input dcm_exec_t ex);
      logic sizeOk;
      logic dirOk;
      logic dataEq;
      logic dataOk;
      sizeOk = !hasSize || !ctl[CTL_SIZE_EN_BIT] || (ctl[CTL_SIZE_VAL_BIT] == bus.byteSize);
      dirOk = !ctl[CTL_DIR_EN_BIT] || (ctl[CTL_DIR_VAL_BIT] == bus.read);
      dataEq = ((bus.data ^ dCmp) & dMask) == 16'h0000;
      dataOk = !hasData || (ctl[CTL_NDB_BIT] ? !dataEq : dataEq);
      if (!ctl[CTL_ON_BIT])
      begin
         chanMatch = 1'b0;
      end
      else if (ctl[CTL_TAG_BIT])
      begin
         // tagged: only execution of the opcode at the compare address counts
         chanMatch = ex.valid && (ex.addr == cmpAddr);
      end
      else
      begin
         chanMatch = bus.valid && (bus.addr == cmpAddr) && sizeOk && dirOk && dataOk;
      end
   endfunction

   // ***************************************
   // bus slave
   // ***************************************
   assign wrFire = s_axi_awvalid && s_axi_wvalid && awReadyReg;
   assign rdFire = s_axi_arvalid && arReadyReg;
   assign wrIdx = regIndex(s_axi_awaddr);
   assign rdIdx = regIndex(s_axi_araddr);
   assign wrByte = s_axi_wdata[7:0];
   assign armWr = wrFire && s_axi_wstrb[0] && isMapped(s_axi_awaddr) && wrIdx == MAIN_CTRL_IDX
                  && wrByte[MAIN_ARM_BIT];
   // comparator bytes are frozen for the whole session
   assign cmpWrOk = wrFire && s_axi_wstrb[0] && !armedReg && isMapped(s_axi_awaddr);

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         awReadyReg <= 1'b0;
         bValidReg <= 1'b0;
         bRespReg <= RESP_OKAY;
      end
      else
      begin
         awReadyReg <= s_axi_awvalid && s_axi_wvalid && !awReadyReg && !bValidReg;
         if (wrFire)
         begin
            bValidReg <= 1'b1;
            bRespReg <= isMapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            bValidReg <= 1'b0;
         end
      end
   end

   always_comb
   begin
      rdMapped = isMapped(s_axi_araddr);
      rdByte = 8'h00;
      unique case (rdIdx)
         MAIN_CTRL_IDX: rdByte = {armedReg, 2'h0, brkEnReg, 2'h0, winSelReg};
         MATCH_FLAGS_IDX: rdByte = (winSelReg == WIN_FLAGS) ? {5'h00, flagsReg} : 8'h00;
         CMP_CTRL_IDX: rdByte = (winSelReg == WIN_FLAGS) ? 8'h00 : ctrlReg[winSelReg];
         CMP_ADDR_HI_IDX: rdByte = (winSelReg == WIN_FLAGS) ? 8'h00 : {6'h00, addrHiReg[winSelReg]};
         CMP_ADDR_MID_IDX: rdByte = (winSelReg == WIN_FLAGS) ? 8'h00 : addrMidReg[winSelReg];
         CMP_ADDR_LO_IDX: rdByte = (winSelReg == WIN_FLAGS) ? 8'h00 : addrLoReg[winSelReg];
         CMP_DATA_HI_IDX: rdByte = (winSelReg == WIN_COMP_A) ? dataCmpReg[15:8] : 8'h00;
         CMP_DATA_LO_IDX: rdByte = (winSelReg == WIN_COMP_A) ? dataCmpReg[7:0] : 8'h00;
         CMP_MASK_HI_IDX: rdByte = (winSelReg == WIN_COMP_A) ? dataMaskReg[15:8] : 8'h00;
         CMP_MASK_LO_IDX: rdByte = (winSelReg == WIN_COMP_A) ? dataMaskReg[7:0] : 8'h00;
         default: rdByte = 8'h00;
      endcase
      if (!rdMapped)
      begin
         rdByte = 8'h00;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         arReadyReg <= 1'b0;
         rValidReg <= 1'b0;
         rRespReg <= RESP_OKAY;
         rDataReg <= 32'h00000000;
      end
      else
      begin
         arReadyReg <= s_axi_arvalid && !arReadyReg && !rValidReg;
         if (rdFire)
         begin
            rValidReg <= 1'b1;
            rDataReg <= {24'h000000, rdByte};
            rRespReg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
         begin
            rValidReg <= 1'b0;
         end
      end
   end

   // ***************************************
   // main control: window select, breakpoint enable, arm
   // ***************************************
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         winSelReg <= WIN_COMP_A;
         brkEnReg <= 1'b0;
         armedReg <= 1'b0;
      end
      else
      begin
         if (wrFire && s_axi_wstrb[0] && isMapped(s_axi_awaddr) && wrIdx == MAIN_CTRL_IDX)
         begin
            winSelReg <= wrByte[1:0];
            brkEnReg <= wrByte[MAIN_BRK_EN_BIT];
            armedReg <= wrByte[MAIN_ARM_BIT];
         end
         else if (breakHit)
         begin
            armedReg <= 1'b0;
         end
      end
   end

   // ***************************************
   // comparator register bank
   // ***************************************
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_CHAN; i++)
         begin
            ctrlReg[i] <= REG_RESET;
            addrHiReg[i] <= 2'h0;
            addrMidReg[i] <= REG_RESET;
            addrLoReg[i] <= REG_RESET;
         end
         dataCmpReg <= 16'h0000;
         dataMaskReg <= 16'h0000;
      end
      else if (cmpWrOk && winSelReg != WIN_FLAGS)
      begin
         // flag index is read-only: no branch for it, so writes there vanish
         unique case (wrIdx)
            CMP_CTRL_IDX: ctrlReg[winSelReg] <= wrByte & ((winSelReg == WIN_COMP_A) ? CTL_WMASK_A : CTL_WMASK_BC);
            CMP_ADDR_HI_IDX: addrHiReg[winSelReg] <= wrByte[1:0];
            CMP_ADDR_MID_IDX: addrMidReg[winSelReg] <= wrByte;
            CMP_ADDR_LO_IDX: addrLoReg[winSelReg] <= wrByte;
            CMP_DATA_HI_IDX: if (winSelReg == WIN_COMP_A) dataCmpReg[15:8] <= wrByte;
            CMP_DATA_LO_IDX: if (winSelReg == WIN_COMP_A) dataCmpReg[7:0] <= wrByte;
            CMP_MASK_HI_IDX: if (winSelReg == WIN_COMP_A) dataMaskReg[15:8] <= wrByte;
            CMP_MASK_LO_IDX: if (winSelReg == WIN_COMP_A) dataMaskReg[7:0] <= wrByte;
            default: ;
         endcase
      end
   end

   // ***************************************
   // matching and session events
   // ***************************************
   always_comb
   begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         // channel 2 stores bits 7:6 but nothing reads them there, so it has no size check
         chanHit[i] = chanMatch(ctrlReg[i], {addrHiReg[i], addrMidReg[i], addrLoReg[i]}, i != 2, i == 0,
                                dataCmpReg, dataMaskReg, coreBus, coreExec);
      end
   end

   assign sessionHit = armedReg ? chanHit : 3'h0;
   assign breakHit = |(sessionHit & {ctrlReg[2][CTL_BREAK_BIT], ctrlReg[1][CTL_BREAK_BIT],
                                     ctrlReg[0][CTL_BREAK_BIT]});
   // a session match in the cycle of an arm write made while already armed still lands, the set wins over the clear
   assign flagsNext = (armWr ? 3'h0 : flagsReg) | sessionHit;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         flagsReg <= 3'h0;
      end
      else
      begin
         flagsReg <= flagsNext;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         eventReg <= '0;
      end
      else
      begin
         eventReg.match <= sessionHit;
         eventReg.first <= lowestOne(sessionHit);
         eventReg.breakpoint <= breakHit && brkEnReg;
         eventReg.traceStop <= breakHit;
         eventReg.armed <= armedReg;
      end
   end

   assign s_axi_awready = awReadyReg;
   assign s_axi_wready = awReadyReg;
   assign s_axi_bvalid = bValidReg;
   assign s_axi_bresp = bRespReg;
   assign s_axi_arready = arReadyReg;
   assign s_axi_rvalid = rValidReg;
   assign s_axi_rresp = rRespReg;
   assign s_axi_rdata = rDataReg;
   assign debugEvent = eventReg;

   // ***************************************
   // checks
   // ***************************************
   flags_no_clear_a: assert property (
      @(posedge core_clk) disable iff (rst) !armWr |=> ((flagsReg & $past(flagsReg)) == $past(flagsReg)))
      else $error("match flags dropped without arming");

   flag_set_a: assert property (
      @(posedge core_clk) disable iff (rst) sessionHit[1] |=> flagsReg[1] && eventReg.match[1])
      else $error("session match did not set its flag");

   flag_window_a: assert property (
      @(posedge core_clk) disable iff (rst)
      rdFire && s_axi_araddr == {MATCH_FLAGS_IDX, 2'h0} && winSelReg == WIN_FLAGS
      |=> s_axi_rvalid && s_axi_rdata[2:0] == $past(flagsReg) && s_axi_rdata[31:3] == 29'h0)
      else $error("flag register read wrong");

   unimpl_zero_a: assert property (
      @(posedge core_clk) disable iff (rst)
      rdFire && s_axi_araddr == {CMP_MASK_HI_IDX, 2'h0} && winSelReg != WIN_COMP_A |=> s_axi_rdata == 32'h0)
      else $error("unimplemented byte did not read zero");

   armed_freeze_a: assert property (
      @(posedge core_clk) disable iff (rst)
      armedReg && wrFire |=> ctrlReg[0] == $past(ctrlReg[0]) && addrLoReg[0] == $past(addrLoReg[0]))
      else $error("comparator written while armed");

   off_no_match_a: assert property (
      @(posedge core_clk) disable iff (rst) !ctrlReg[2][CTL_ON_BIT] |=> !eventReg.match[2])
      else $error("disabled comparator matched");

   dir_mismatch_a: assert property (
      @(posedge core_clk) disable iff (rst)
      ctrlReg[1][CTL_DIR_EN_BIT] && !ctrlReg[1][CTL_TAG_BIT] && coreBus.read != ctrlReg[1][CTL_DIR_VAL_BIT]
      |=> !eventReg.match[1])
      else $error("direction mismatch still matched");

   break_end_a: assert property (
      @(posedge core_clk) disable iff (rst)
      breakHit && !(wrFire && wrIdx == MAIN_CTRL_IDX) |=> !armedReg && eventReg.traceStop ##1 !eventReg.traceStop)
      else $error("break match did not end session");

   brk_gate_a: assert property (
      @(posedge core_clk) disable iff (rst) eventReg.breakpoint |-> $past(brkEnReg) && eventReg.traceStop)
      else $error("breakpoint without module enable");

   low_first_a: assert property (
      @(posedge core_clk) disable iff (rst) eventReg.match[0] |-> eventReg.first == 3'h1)
      else $error("lowest channel not reported first");
endmodule
`default_nettype wire

// >>> rtl/dcm_pkg.sv
// Purpose: shared constants and carriers for the debug comparator match block
// Assumes: register bus is AXI4-Lite, 32-bit data, one 8-bit register per aligned word
// Notes: register indices are word indices; byte address is four times the index
package dcm_pkg;
   // ***************************************
   // register indices and addressing
   // ***************************************
   localparam logic [5:0] MAIN_CTRL_IDX = 6'h20;
   localparam logic [5:0] MATCH_FLAGS_IDX = 6'h27;
   localparam logic [5:0] CMP_CTRL_IDX = 6'h28;
   localparam logic [5:0] CMP_ADDR_HI_IDX = 6'h29;
   localparam logic [5:0] CMP_ADDR_MID_IDX = 6'h2A;
   localparam logic [5:0] CMP_ADDR_LO_IDX = 6'h2B;
   localparam logic [5:0] CMP_DATA_HI_IDX = 6'h2C;
   localparam logic [5:0] CMP_DATA_LO_IDX = 6'h2D;
   localparam logic [5:0] CMP_MASK_HI_IDX = 6'h2E;
   localparam logic [5:0] CMP_MASK_LO_IDX = 6'h2F;
   localparam int AXI_ADDR_W = 8;
   // ***************************************
   // field positions
   // ***************************************
   localparam int MAIN_ARM_BIT = 7;
   localparam int MAIN_BRK_EN_BIT = 4;
   localparam int CTL_SIZE_EN_BIT = 7;
   localparam int CTL_SIZE_VAL_BIT = 6;
   localparam int CTL_TAG_BIT = 5;
   localparam int CTL_BREAK_BIT = 4;
   localparam int CTL_DIR_VAL_BIT = 3;
   localparam int CTL_DIR_EN_BIT = 2;
   localparam int CTL_NDB_BIT = 1;
   localparam int CTL_ON_BIT = 0;
   localparam int NUM_CHAN = 3;
   // ***************************************
   // codes and reset values
   // ***************************************
   localparam logic [1:0] WIN_COMP_A = 2'h0;
   localparam logic [1:0] WIN_COMP_B = 2'h1;
   localparam logic [1:0] WIN_COMP_C = 2'h2;
   localparam logic [1:0] WIN_FLAGS = 2'h3;
   localparam logic [7:0] CTL_WMASK_A = 8'hFF;
   localparam logic [7:0] CTL_WMASK_BC = 8'hFD;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ***************************************
   // carriers
   // ***************************************
   typedef struct packed {
      logic valid;
      logic read;
      logic byteSize;
      logic [17:0] addr;
      logic [15:0] data;
   } dcm_core_bus_t;
   typedef struct packed {
      logic valid;
      logic [17:0] addr;
   } dcm_exec_t;
   typedef struct packed {
      logic [2:0] match;
      logic [2:0] first;
      logic breakpoint;
      logic traceStop;
      logic armed;
   } dcm_event_t;
endpackage

// >>> test/dcm_core_model.sv
// Purpose: behavioural processor core driving the buses that the comparators watch
// Assumes: one bus cycle lasts one clock and is launched right after a rising edge
// Notes: released lines carry the inverse of the last value, so stale data never matches by chance
`timescale 1ns/10ps
`default_nettype none
module dcm_core_model
(
   // clock
   input wire logic core_clk,
   // core buses
   output var dcm_pkg::dcm_core_bus_t coreBus,
   output var dcm_pkg::dcm_exec_t coreExec
);
   import dcm_pkg::*;
   initial
   begin
      coreBus = '0;
      coreExec = '0;
   end
   // ****************
   // data bus cycle
   // ****************
   task automatic busCycle(input logic r, input logic bs, input logic [17:0] a, input logic [15:0] d);
      @(posedge core_clk);
      coreBus <= '{valid: 1'b1, read: r, byteSize: bs, addr: a, data: d};
      @(posedge core_clk);
      coreBus <= '{valid: 1'b0, read: ~r, byteSize: ~bs, addr: ~a, data: ~d};
   endtask
   // ****************
   // opcode reaching execution
   // ****************
   task automatic execCycle(input logic [17:0] a);
      @(posedge core_clk);
      coreExec <= '{valid: 1'b1, addr: a};
      @(posedge core_clk);
      coreExec <= '{valid: 1'b0, addr: ~a};
   endtask
endmodule
`default_nettype wire

// >>> test/tb_debug_comparator_match.sv
// Purpose: self-checking bench for the debug comparator match block
// Assumes: AXI4-Lite master tasks here, core bus driven by dcm_core_model
// Notes: expectations come from the register map and field positions only
`timescale 1ns/10ps
`default_nettype none
module tb_debug_comparator_match;
   import dcm_pkg::*;
   // ****************
   // signals
   // ****************
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, lastResp;
   logic [31:0] rdata, lastData;
   dcm_core_bus_t coreBus;
   dcm_exec_t coreExec;
   dcm_event_t debugEvent;
   int fails = 0;
   int testsRun = 0;
   localparam logic [17:0] HIT = 18'h2A5C3;
   always #10 core_clk = ~core_clk;
   dcm_match dut
   (
      .core_clk(core_clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .coreBus(coreBus), .coreExec(coreExec), .debugEvent(debugEvent)
   );
   dcm_core_model core
   (
      .core_clk(core_clk), .coreBus(coreBus), .coreExec(coreExec)
   );
   // ****************
   // reporting
   // ****************
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic timedOut;
      fails++;
      $display("[ERR] bus answer expected 1 seen 0");
      wrap_up();
   endtask
   // ****************
   // register bus master
   // ****************
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      int n;
      @(posedge core_clk);
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (n > 50) timedOut();
      end
      while (!bvalid);
      lastResp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx);
      int n;
      @(posedge core_clk);
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         if (arready) arvalid <= 1'b0;
         if (n > 50) timedOut();
      end
      while (!rvalid);
      lastData = rdata;
      lastResp = rresp;
      rready <= 1'b0;
   endtask
   // ****************
   // helpers
   // ****************
   task automatic setMain(input logic arm, input logic immediate_break_select, input logic [1:0] win);
      wr(MAIN_CTRL_IDX, {arm, 2'b00, immediate_break_select, 2'b00, win});
   endtask
   // disarms first, since the window only takes writes while disarmed
   task automatic prog(input logic [1:0] ch, input logic [7:0] ctl, input logic [17:0] a);
      setMain(1'b0, 1'b0, ch);
      wr(CMP_CTRL_IDX, ctl);
      wr(CMP_ADDR_HI_IDX, {6'h00, a[17:16]});
      wr(CMP_ADDR_MID_IDX, a[15:8]);
      wr(CMP_ADDR_LO_IDX, a[7:0]);
   endtask
   task automatic probe(input string nm, input logic r, input logic bs, input logic [17:0] a,
      input logic [15:0] d, input logic [2:0] exp);
      core.busCycle(r, bs, a, d);
      #1;
      chk(nm, 32'(exp), 32'(debugEvent.match));
   endtask
   task automatic attr(input string nm, input logic [7:0] ctl, input logic bs, input logic [15:0] d,
      input logic [2:0] exp);
      prog(WIN_COMP_A, ctl, HIT);
      setMain(1'b1, 1'b0, WIN_FLAGS);
      probe(nm, 1'b0, bs, HIT, d, exp);
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      chk("idle events", 32'h0, 32'(debugEvent));
      setMain(1'b0, 1'b0, WIN_FLAGS);
      rd(MATCH_FLAGS_IDX);
      chk("flags after reset", 32'h0, lastData);
      rd(6'h3F);
      chk("unmapped resp", 32'(RESP_SLVERR), 32'(lastResp));
      $display("reset test done");
   endtask
   task automatic t_window;
      logic [7:0] v;
      logic [7:0] e;
      for (int c = 0; c < 4; c++)
      begin
         setMain(1'b0, 1'b0, 2'(c));
         for (int i = 0; i < 8; i++)
            wr(CMP_CTRL_IDX + 6'(i), ~{3'b101, 2'(c), 3'(i)});
         for (int i = 0; i < 8; i++)
         begin
            v = ~{3'b101, 2'(c), 3'(i)};
            e = (c == 3 || (c > 0 && i > 3)) ? 8'h00 : v;
            if (i == 1) e = e & 8'h03;
            if (i == 0 && c > 0) e = e & CTL_WMASK_BC;
            rd(CMP_CTRL_IDX + 6'(i));
            chk("window byte", 32'(e), lastData);
         end
      end
      $display("window test done");
   endtask
   task automatic t_match;
      prog(WIN_COMP_A, 8'h01, HIT);
      // window sweep left a live data mask behind; clear it so data never blocks
      wr(CMP_MASK_HI_IDX, 8'h00);
      wr(CMP_MASK_LO_IDX, 8'h00);
      prog(WIN_COMP_B, 8'h0D, HIT);
      prog(WIN_COMP_C, 8'h00, HIT);
      setMain(1'b1, 1'b0, WIN_FLAGS);
      probe("write cycle", 1'b0, 1'b0, HIT, 16'h0, 3'b001);
      probe("read cycle", 1'b1, 1'b0, HIT, 16'h0, 3'b011);
      chk("lowest first", 32'h1, 32'(debugEvent.first));
      chk("armed out", 32'h1, 32'(debugEvent.armed));
      probe("bit17 off", 1'b1, 1'b0, HIT ^ 18'h20000, 16'h0, 3'b000);
      probe("repeat", 1'b0, 1'b0, HIT, 16'h0, 3'b001);
      wr(MATCH_FLAGS_IDX, 8'h00);
      chk("flag write resp", 32'(RESP_OKAY), 32'(lastResp));
      rd(MATCH_FLAGS_IDX);
      chk("flags kept", 32'h3, lastData);
      setMain(1'b1, 1'b0, WIN_COMP_A);
      wr(CMP_CTRL_IDX, 8'h00);
      probe("armed write", 1'b0, 1'b0, HIT, 16'h0, 3'b001);
      setMain(1'b0, 1'b0, WIN_FLAGS);
      rd(MATCH_FLAGS_IDX);
      chk("rearm clears", 32'h1, lastData);
      $display("match test done");
   endtask
   task automatic t_attr;
      setMain(1'b0, 1'b0, WIN_COMP_A);
      wr(CMP_DATA_HI_IDX, 8'h12);
      wr(CMP_DATA_LO_IDX, 8'hAB);
      wr(CMP_MASK_HI_IDX, 8'h00);
      wr(CMP_MASK_LO_IDX, 8'hFF);
      attr("byte want word", 8'hC1, 1'b0, 16'h12AB, 3'b000);
      attr("byte", 8'hC1, 1'b1, 16'h12AB, 3'b001);
      attr("word want byte", 8'h81, 1'b1, 16'h12AB, 3'b000);
      attr("masked high", 8'h01, 1'b0, 16'h77AB, 3'b001);
      attr("data differs", 8'h01, 1'b0, 16'h12AC, 3'b000);
      attr("inverted", 8'h03, 1'b0, 16'h12AC, 3'b001);
      attr("tag bus", 8'h21, 1'b0, 16'h12AB, 3'b000);
      attr("tag ignores", 8'hEF, 1'b0, 16'h12AB, 3'b000);
      core.execCycle(HIT);
      #1;
      chk("tag exec", 32'h1, 32'(debugEvent.match));
      $display("attribute test done");
   endtask
   task automatic t_break;
      prog(WIN_COMP_A, 8'h11, HIT);
      setMain(1'b1, 1'b1, WIN_FLAGS);
      core.busCycle(1'b0, 1'b0, HIT, 16'h12AB);
      #1;
      chk("breakpoint", 32'h1, 32'(debugEvent.breakpoint));
      chk("trace stop", 32'h1, 32'(debugEvent.traceStop));
      rd(MAIN_CTRL_IDX);
      chk("disarmed", 32'h13, lastData);
      chk("armed out low", 32'h0, 32'(debugEvent.armed));
      setMain(1'b1, 1'b0, WIN_FLAGS);
      core.busCycle(1'b0, 1'b0, HIT, 16'h12AB);
      #1;
      chk("break disabled", 32'h0, 32'(debugEvent.breakpoint));
      $display("break test done");
   endtask
   initial
   begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_window();
      t_match();
      t_attr();
      t_break();
      wrap_up();
   end
endmodule
`default_nettype wire
